// File: src/ttc_thermal_throttle.sv
// Thermal throttle control: clock modulation, alert pin, trip output, per-core thermal interrupts and core 0 sensor status.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"

module ttc_thermal_throttle #(
    parameter int NUM_CORES = 2
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Avalon-MM register slave.
    input wire ttc_pkg::ttc_avm_req_t i_avm,
    output logic [31:0] o_avm_readdata,
    output logic o_avm_waitrequest,
    // Per-core sensor offsets below maximum, and die temperature in degrees C.
    input wire logic [NUM_CORES*7-1:0] i_core_offset,
    input wire logic [7:0] i_die_temp_c,
    // Package power state.
    input wire ttc_pkg::ttc_pwr_t i_pwr_state,
    // Alert pin, active low, open drain.
    input wire logic i_thermal_alert_pin_n,
    output logic o_thermal_alert_pin_n,
    output logic o_thermal_alert_pin_oe,
    // Clock gating and events.
    output logic o_core_clk_en,
    output logic o_catastrophic_trip_out_n,
    output logic [NUM_CORES-1:0] o_core_thermal_irq
);
    import ttc_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] cfg_reg, cfg_next;
    logic [31:0] thr_reg, thr_next;
    logic [7:0] sticky_reg, sticky_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wait_reg, wait_next;

    // ----------------------------------------
    // Thermal state
    // ----------------------------------------
    logic ext_s1_reg, ext_s2_reg, ext_prev_reg;
    logic alert_d1_reg, alert_d2_reg;
    logic prime_reg;
    logic trip_n_reg, trip_n_next;
    logic hot_reg, hot_next;
    logic alert_reg, alert_next;
    logic trip_reg, trip_next;
    logic [7:0] phase_reg, phase_next;
    logic clk_en_reg, clk_en_next;
    ttc_thr_t mode_reg, mode_next;
    logic [15:0] oos_cnt_reg, oos_cnt_next;
    logic oos_reg, oos_next;
    logic [NUM_CORES-1:0] irq_reg, irq_next;
    logic [NUM_CORES-1:0] core_hot;
    logic [NUM_CORES-1:0] thr_a_below, thr_b_below;
    logic [NUM_CORES-1:0] thr_a_prev_reg, thr_b_prev_reg;
    logic [NUM_CORES-1:0] thr_evt;
    logic ext_hot;
    logic any_hot;
    logic any_cool;
    logic [2:0] duty;

    genvar g;
    generate
        for (g = 0; g < NUM_CORES; g++)
        begin : g_core
            logic [6:0] ofs;
            assign ofs = i_core_offset[g*7 +: 7];
            assign core_hot[g] = (ofs == 7'h00);
            assign thr_a_below[g] = (ofs <= thr_reg[6:0]);
            assign thr_b_below[g] = (ofs <= thr_reg[14:8]);
            // The first cycle after reset has no valid previous level to compare with.
            assign thr_evt[g] = prime_reg & ((thr_a_below[g] != thr_a_prev_reg[g])
                              | (thr_b_below[g] != thr_b_prev_reg[g]));
        end
    endgenerate

    always_comb
    begin
        any_cool = 1'b1;
        for (int i = 0; i < NUM_CORES; i++)
        begin
            if (i_core_offset[i*7 +: 7] < `TTC_HYST)
            begin
                any_cool = 1'b0;
            end
        end
    end

    assign any_hot = |core_hot;
    // external pull low; ext_s1_reg only feeds ext_s2_reg
    // Our own drive shows at the synchroniser output two cycles late, so a copy
    // delayed to match masks it; otherwise every release would throttle briefly.
    assign ext_hot = ~ext_s2_reg & ~alert_d2_reg;
    assign duty = ctrl_reg[`TTC_CTRL_DUTY_MSB:`TTC_CTRL_DUTY_LSB];

    // ----------------------------------------
    // Thermal next state
    // ----------------------------------------
    always_comb
    begin
        hot_next = hot_reg;
        // set at trip, clear below band
        if (any_hot)
        begin
            hot_next = 1'b1;
        end
        else if (any_cool)
        begin
            hot_next = 1'b0;
        end

        alert_next = alert_reg;
        case (i_pwr_state)
            TTC_PWR_NORMAL:
            begin
                alert_next = hot_reg;
            end
            TTC_PWR_LOW:
            begin
                alert_next = alert_reg;
            end
            TTC_PWR_DEEP:
            begin
                alert_next = 1'b0;
            end
            default:
            begin
                alert_next = 1'b0;
            end
        endcase

        trip_next = trip_reg | (i_die_temp_c >= 8'(`TTC_CAT_TEMP_C));
        trip_n_next = ~trip_next;

        // automatic first, package-wide, force ignores external
        if (cfg_reg[`TTC_CFG_AUTO_EN] & (hot_reg | ext_hot))
        begin
            mode_next = TTC_THR_AUTO;
        end
        else if (cfg_reg[`TTC_CFG_FORCE_AUTO] & hot_reg)
        begin
            mode_next = TTC_THR_AUTO;
        end
        else if (ctrl_reg[`TTC_CTRL_ODM_EN])
        begin
            mode_next = TTC_THR_ODM;
        end
        else
        begin
            mode_next = TTC_THR_OFF;
        end

        phase_next = (phase_reg == `TTC_MOD_PERIOD - 8'h01) ? 8'h00 : phase_reg + 8'h01;
        case (mode_reg)
            TTC_THR_AUTO:
            begin
                clk_en_next = phase_next < (`TTC_MOD_PERIOD >> 1);
            end
            TTC_THR_ODM:
            begin
                // duty eighths; zero code is treated as one eighth
                clk_en_next = phase_next < ((duty == 3'h0) ? 8'h01 : {5'h00, duty});
            end
            default:
            begin
                clk_en_next = 1'b1;
            end
        endcase
        if (trip_reg)
        begin
            clk_en_next = 1'b0;
        end

        oos_cnt_next = 16'h0000;
        oos_next = oos_reg;
        if ((mode_reg == TTC_THR_AUTO) & hot_reg)
        begin
            oos_cnt_next = (oos_cnt_reg == `TTC_OOS_CYCLES) ? oos_cnt_reg : oos_cnt_reg + 16'h0001;
            oos_next = (oos_cnt_reg == `TTC_OOS_CYCLES);
        end
        else
        begin
            oos_next = 1'b0;
        end
    end

    // ----------------------------------------
    // Register bus and sticky status
    // ----------------------------------------
    logic evt_rise, evt_fall, evt_oos;
    // Edges come from the synchronised pin, so an external pull raises them too.
    assign evt_rise = ~ext_s2_reg & ext_prev_reg;
    assign evt_fall = ext_s2_reg & ~ext_prev_reg;
    assign evt_oos = oos_next & ~oos_reg;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        cfg_next = cfg_reg;
        thr_next = thr_reg;
        rdata_next = rdata_reg;
        sticky_next = sticky_reg;
        wait_next = 1'b1;
        irq_next = '0;
        // Single wait state: a request is accepted the cycle after it is first seen.
        if ((i_avm.read | i_avm.write) & wait_reg)
        begin
            wait_next = 1'b0;
        end
        if ((i_avm.read | i_avm.write) & ~wait_reg)
        begin
            wait_next = 1'b1;
        end
        if (i_avm.write & ~wait_reg)
        begin
            case (i_avm.address)
                `TTC_ADDR_CTRL: ctrl_next = {27'h0, i_avm.writedata[4:1], 1'b0};
                `TTC_ADDR_CFG: cfg_next = {28'h0, i_avm.writedata[3:0]};
                `TTC_ADDR_THR: thr_next = {17'h0, i_avm.writedata[14:8], 1'b0, i_avm.writedata[6:0]};
                `TTC_ADDR_STATUS: sticky_next = sticky_reg & ~i_avm.writedata[15:8];
                default: ;
            endcase
        end
        if (i_avm.read & wait_reg)
        begin
            case (i_avm.address)
                `TTC_ADDR_CTRL: rdata_next = ctrl_reg;
                `TTC_ADDR_CFG: rdata_next = cfg_reg;
                `TTC_ADDR_THR: rdata_next = thr_reg;
                `TTC_ADDR_STATUS: rdata_next = {16'h0, sticky_reg, 3'h0, trip_reg,
                                                oos_reg, alert_reg, mode_reg};
                `TTC_ADDR_TEMP: rdata_next = {16'h0, 7'h0,
                                              i_pwr_state == TTC_PWR_NORMAL,
                                              1'b0, i_core_offset[6:0]};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        // edge interrupts; set wins over clear
        if (evt_rise & cfg_reg[`TTC_CFG_IRQ_RISE])
        begin
            sticky_next[0] = 1'b1;
        end
        if (evt_fall & cfg_reg[`TTC_CFG_IRQ_FALL])
        begin
            sticky_next[1] = 1'b1;
        end
        if (evt_oos)
        begin
            sticky_next[2] = 1'b1;
        end
        if (|thr_evt)
        begin
            sticky_next[3] = 1'b1;
        end
        // thermal interrupts pulse to the local controller, which latches them
        for (int i = 0; i < NUM_CORES; i++)
        begin
            irq_next[i] = (evt_rise & cfg_reg[`TTC_CFG_IRQ_RISE])
                        | (evt_fall & cfg_reg[`TTC_CFG_IRQ_FALL])
                        | evt_oos | thr_evt[i];
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_reg <= `TTC_CTRL_RESET;
            cfg_reg <= `TTC_CFG_RESET;
            thr_reg <= `TTC_THR_RESET;
            sticky_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b1;
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            ext_prev_reg <= 1'b1;
            alert_d1_reg <= 1'b0;
            alert_d2_reg <= 1'b0;
            prime_reg <= 1'b0;
            trip_n_reg <= 1'b1;
            hot_reg <= 1'b0;
            alert_reg <= 1'b0;
            trip_reg <= 1'b0;
            phase_reg <= 8'h00;
            clk_en_reg <= 1'b1;
            mode_reg <= TTC_THR_OFF;
            oos_cnt_reg <= 16'h0000;
            oos_reg <= 1'b0;
            irq_reg <= '0;
            thr_a_prev_reg <= '0;
            thr_b_prev_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            cfg_reg <= cfg_next;
            thr_reg <= thr_next;
            sticky_reg <= sticky_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
            ext_s1_reg <= i_thermal_alert_pin_n;
            ext_s2_reg <= ext_s1_reg;
            ext_prev_reg <= ext_s2_reg;
            alert_d1_reg <= alert_reg;
            alert_d2_reg <= alert_d1_reg;
            prime_reg <= 1'b1;
            trip_n_reg <= trip_n_next;
            hot_reg <= hot_next;
            alert_reg <= alert_next;
            trip_reg <= trip_next;
            phase_reg <= phase_next;
            clk_en_reg <= clk_en_next;
            mode_reg <= mode_next;
            oos_cnt_reg <= oos_cnt_next;
            oos_reg <= oos_next;
            irq_reg <= irq_next;
            thr_a_prev_reg <= thr_a_below;
            thr_b_prev_reg <= thr_b_below;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // The pin is open drain: drive low only, never high.
    assign o_thermal_alert_pin_n = 1'b0;
    assign o_thermal_alert_pin_oe = alert_reg;
    assign o_core_clk_en = clk_en_reg;
    assign o_catastrophic_trip_out_n = trip_n_reg;
    assign o_core_thermal_irq = irq_reg;
    assign o_avm_readdata = rdata_reg;
    assign o_avm_waitrequest = wait_reg;

endmodule : ttc_thermal_throttle
`default_nettype wire

// File: src/ttc_cfg.svh
// Register map, field positions, reset values and timing counts of the thermal throttle block.
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

`define TTC_ADDR_CTRL 4'h0
`define TTC_ADDR_CFG 4'h1
`define TTC_ADDR_STATUS 4'h2
`define TTC_ADDR_TEMP 4'h3
`define TTC_ADDR_THR 4'h4

`define TTC_CTRL_ODM_EN 4
`define TTC_CTRL_DUTY_LSB 1
`define TTC_CTRL_DUTY_MSB 3
`define TTC_CTRL_RESET 32'h0000_0000
`define TTC_CFG_AUTO_EN 0
`define TTC_CFG_FORCE_AUTO 1
`define TTC_CFG_IRQ_RISE 2
`define TTC_CFG_IRQ_FALL 3
`define TTC_CFG_RESET 32'h0000_0001
`define TTC_THR_RESET 32'h0000_0a14

`define TTC_HYST 7'h02
`define TTC_CAT_TEMP_C 125
`define TTC_MOD_PERIOD 8'h08
`define TTC_OOS_CYCLES 16'h0400

`endif

// File: src/ttc_pkg.sv
// Types shared by the thermal throttle block.
package ttc_pkg;

    typedef enum logic [1:0] {
        TTC_PWR_NORMAL = 2'b00,
        TTC_PWR_LOW = 2'b01,
        TTC_PWR_DEEP = 2'b10
    } ttc_pwr_t;

    typedef enum logic [1:0] {
        TTC_THR_OFF = 2'b00,
        TTC_THR_AUTO = 2'b01,
        TTC_THR_ODM = 2'b10
    } ttc_thr_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } ttc_avm_req_t;

    typedef struct packed {
        logic [6:0] offset;
        logic valid;
    } ttc_core_temp_t;

endpackage : ttc_pkg

// File: testbench/ttc_thermal_throttle_checker.sv
// Port-level assertion checker for the thermal throttle block.
`timescale 1ns/1ps
`default_nettype none
module ttc_thermal_throttle_checker #(
    parameter int NUM_CORES = 2
) (
    // Clock, reset and bus.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire ttc_pkg::ttc_avm_req_t i_avm,
    input wire logic [31:0] o_avm_readdata,
    input wire logic o_avm_waitrequest,
    // Sensors and power.
    input wire logic [NUM_CORES*7-1:0] i_core_offset,
    input wire logic [7:0] i_die_temp_c,
    input wire ttc_pkg::ttc_pwr_t i_pwr_state,
    // Pin, clock gating and events.
    input wire logic i_thermal_alert_pin_n,
    input wire logic o_thermal_alert_pin_n,
    input wire logic o_thermal_alert_pin_oe,
    input wire logic o_core_clk_en,
    input wire logic o_catastrophic_trip_out_n,
    input wire logic [NUM_CORES-1:0] o_core_thermal_irq
);
    import ttc_pkg::*;
    // --------
    // Properties.
    // --------
    logic any_hot;
    always_comb
    begin
        any_hot = 1'b0;
        for (int c = 0; c < NUM_CORES; c++)
        begin
            if (i_core_offset[c*7 +: 7] == 7'h00)
            begin
                any_hot = 1'b1;
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_bus_req;
        (i_avm.read || i_avm.write) && o_avm_waitrequest;
    endsequence
    sequence s_hot_normal;
        (any_hot && i_pwr_state == TTC_PWR_NORMAL) [*3];
    endsequence
    a_bus_accept: assert property (s_bus_req |=> !o_avm_waitrequest)
        else $error("bus request not accepted in the next cycle");
    a_bus_cause: assert property (!o_avm_waitrequest |-> $past(i_avm.read || i_avm.write))
        else $error("bus answer without a request");
    a_hot_alert: assert property (s_hot_normal |-> o_thermal_alert_pin_oe)
        else $error("alert pin not driven while hot");
    a_low_no_new: assert property (i_pwr_state == TTC_PWR_LOW && !o_thermal_alert_pin_oe
        |=> !o_thermal_alert_pin_oe)
        else $error("alert newly driven in low power");
    a_deep_release: assert property ($past(i_pwr_state) == TTC_PWR_DEEP
        |-> !o_thermal_alert_pin_oe)
        else $error("alert driven in deepest power-down");
    a_trip_heat: assert property (i_die_temp_c >= 8'd125
        |-> ##[1:3] !o_catastrophic_trip_out_n)
        else $error("trip output late");
    a_trip_sticky: assert property (!o_catastrophic_trip_out_n |=> !o_catastrophic_trip_out_n)
        else $error("trip output released");
    a_trip_clk_off: assert property (!o_catastrophic_trip_out_n |=> !o_core_clk_en)
        else $error("core clock runs after trip");
endmodule : ttc_thermal_throttle_checker
bind ttc_thermal_throttle ttc_thermal_throttle_checker #(.NUM_CORES(NUM_CORES)) u_chk (.*);
`default_nettype wire

// File: testbench/ttc_platform_model.sv
// Platform model: pulls the alert pin and removes core supply on a trip.
`timescale 1ns/1ps
`default_nettype none
module ttc_platform_model #(
    parameter int SUPPLY_OFF_CYCLES = 4
) (
    // Clock, reset and command.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_pull_req,
    // Device side.
    input wire logic i_alert_oe,
    input wire logic i_trip_n,
    // Pin level and supply.
    output logic o_pin_n,
    output logic o_supply_on
);
    // --------
    // Pin and supply.
    // --------
    int trip_cnt;
    // external pull low
    // The pin has a pull-up, so it rests high when nobody pulls it.
    assign o_pin_n = !(i_alert_oe || i_pull_req);
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            trip_cnt <= 0;
            o_supply_on <= 1'b1;
        end
        else if (!i_trip_n)
        begin
            trip_cnt <= trip_cnt + 1;
            if (trip_cnt == SUPPLY_OFF_CYCLES - 1)
            begin
                o_supply_on <= 1'b0;
            end
        end
    end
endmodule : ttc_platform_model
`default_nettype wire

// File: testbench/ttc_thermal_throttle_tb.sv
// Self-checking bench for the thermal throttle block.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module ttc_thermal_throttle_tb;
    import ttc_pkg::*;
    // --------
    // Bench state.
    // --------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pull = 1'b0;
    logic pin_n, supply, oe, clk_en, trip_n, hot_exp, wreq, pin_d;
    logic [31:0] rdata;
    logic [1:0] irq;
    logic [31:0] rd, seed = 32'h0000_c1a4;
    logic [13:0] nxt, offs = {2{7'h10}};
    logic [7:0] temp = 8'h32;
    ttc_pwr_t pwr = TTC_PWR_NORMAL;
    ttc_avm_req_t avm = '0;
    logic [3:0] ra[5] = '{`TTC_ADDR_CTRL, `TTC_ADDR_CFG, `TTC_ADDR_THR, 4'h5, `TTC_ADDR_STATUS};
    logic [31:0] rv[5] = '{`TTC_CTRL_RESET, `TTC_CFG_RESET, `TTC_THR_RESET, 32'h0, 32'h0};
    int fails = 0, checked = 0, cyc = 0, n, irqs = 0;
    ttc_thermal_throttle u_ttc_thermal_throttle (.i_clk_sys(clk), .i_rst(rst), .i_avm(avm),
        .o_avm_readdata(rdata), .o_avm_waitrequest(wreq), .i_core_offset(offs),
        .i_die_temp_c(temp), .i_pwr_state(pwr), .i_thermal_alert_pin_n(pin_n),
        .o_thermal_alert_pin_n(pin_d),
        .o_thermal_alert_pin_oe(oe), .o_core_clk_en(clk_en),
        .o_catastrophic_trip_out_n(trip_n), .o_core_thermal_irq(irq));
    ttc_platform_model u_ttc_platform_model (.i_clk_sys(clk), .i_rst(rst), .i_pull_req(pull),
        .i_alert_oe(oe), .i_trip_n(trip_n), .o_pin_n(pin_n), .o_supply_on(supply));
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    // Hysteresis: hot at offset zero, cool only when every core is two or more below.
    function automatic logic hot_fn(input logic h, input logic [13:0] o);
        if (o[6:0] == 0 || o[13:7] == 0)
            return 1'b1;
        if (o[6:0] >= 2 && o[13:7] >= 2)
            return 1'b0;
        return h;
    endfunction : hot_fn
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avm <= '{read: !w, write: w, address: a, writedata: d};
        do
            @(posedge clk);
        while (wreq !== 1'b0);
        rd = rdata;
        avm <= '0;
        @(posedge clk);
    endtask : bus
    // A window of 64 cycles holds exactly eight modulation periods.
    task automatic count_on(output int on);
        on = 0;
        repeat (16) @(posedge clk);
        repeat (64)
        begin
            @(posedge clk);
            on += (clk_en === 1'b1);
        end
    endtask : count_on
    task automatic wait4;
        repeat (4) @(posedge clk);
    endtask : wait4
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    always @(posedge clk)
    begin
        cyc++;
        if (irq !== 2'b00)
            irqs++;
        if (cyc == 6000)
        begin
            fails++;
            test_done();
        end
    end
    // --------
    // Scenarios.
    // --------
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ra[i])
        begin
            bus(1'b0, ra[i], '0);
            check("reset_value", rd, rv[i]);
        end
        for (int d = 0; d < 8; d++)
        begin
            bus(1'b1, `TTC_ADDR_CTRL, 32'h10 | (d << 1));
            count_on(n);
            check("odm_on", n, (d == 0 ? 1 : d) * 8);
        end
        offs <= {7'h00, 7'h10};
        count_on(n);
        check("auto_on", n, 32);
        check("alert_oe", oe, 1'b1);
        check("pin_data", pin_d, 1'b0);
        bus(1'b0, `TTC_ADDR_STATUS, '0);
        check("mode", rd[1:0], TTC_THR_AUTO);
        check("thr_sticky", rd[11], 1'b1);
        repeat (1024) @(posedge clk);
        bus(1'b0, `TTC_ADDR_STATUS, '0);
        check("oos", {rd[10], rd[3]}, 2'b11);
        offs <= {7'h01, 7'h10};
        wait4();
        check("hyst_hold", oe, 1'b1);
        bus(1'b1, `TTC_ADDR_CTRL, '0);
        hot_exp = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            seed = xs(seed);
            nxt = {5'h00, seed[3:2], 5'h00, seed[1:0]};
            offs <= nxt;
            hot_exp = hot_fn(hot_exp, nxt);
            wait4();
            check("alert_rand", oe, hot_exp);
            bus(1'b0, `TTC_ADDR_TEMP, '0);
            check("temp", rd[8:0], {1'b1, 1'b0, nxt[6:0]});
        end
        offs <= {2{7'h10}};
        wait4();
        check("cool_alert", oe, 1'b0);
        pwr <= TTC_PWR_LOW;
        bus(1'b0, `TTC_ADDR_TEMP, '0);
        check("temp_valid", rd[8], 1'b0);
        offs <= {7'h10, 7'h00};
        wait4();
        check("low_alert", oe, 1'b0);
        pwr <= TTC_PWR_NORMAL;
        wait4();
        check("hot_alert", oe, 1'b1);
        pwr <= TTC_PWR_LOW;
        offs <= {2{7'h10}};
        wait4();
        check("held_alert", oe, 1'b1);
        pwr <= TTC_PWR_DEEP;
        wait4();
        check("deep_alert", oe, 1'b0);
        pwr <= TTC_PWR_NORMAL;
        bus(1'b1, `TTC_ADDR_CFG, 32'h5);
        irqs = 0;
        pull <= 1'b1;
        count_on(n);
        check("ext_on", n, 32);
        check("ext_irq", irqs != 0, 1'b1);
        bus(1'b0, `TTC_ADDR_STATUS, '0);
        check("rise_sticky", rd[8], 1'b1);
        bus(1'b1, `TTC_ADDR_STATUS, 32'h0000_ff00);
        bus(1'b0, `TTC_ADDR_STATUS, '0);
        check("sticky_clr", rd[15:8], 8'h00);
        // Force alone must not let the external pull throttle the clocks.
        bus(1'b1, `TTC_ADDR_CFG, 32'h2);
        count_on(n);
        check("force_ext", n, 64);
        pull <= 1'b0;
        temp <= 8'd125;
        wait4();
        check("trip", trip_n, 1'b0);
        check("trip_clk", clk_en, 1'b0);
        repeat (8) @(posedge clk);
        check("supply", supply, 1'b0);
        test_done();
    end
endmodule : ttc_thermal_throttle_tb
`default_nettype wire
